// ===== rtl/epw_pkg.sv
// Package of constants for the EEPROM page-write and protection host controller
//
// Summary of operation
// - Host starts next byte load within 150 us
// - Upper address splits into block and page fields
// - Arm: AA@5555, 55@2AAA, A0@5555
// - Disarm: six fixed writes ending 20@5555
// - One to page-size data bytes after command; the host sends req_count_in bytes unchecked, zero included
// - Protected block writes need arming sequence first
// - Same page and block for all loads of a page
package epw_pkg;
   // Clock period in ns
   localparam int CLK_NS = 5;
   // Byte-load window in us; host keeps gaps well inside it
   localparam int BYTE_LOAD_WINDOW_US = 150;
   // Target gap between loads (ns), a third of the window for margin
   localparam int LOAD_GAP_NS = BYTE_LOAD_WINDOW_US * 1000 / 3;
   // Longest programming time in ms
   localparam int PROG_MAX_MS = 10;
   // Power-on write lockout in ms
   localparam int POWER_LOCK_MS = 5;
   // Write pulse low width and high width in ns
   localparam int WRITE_LOW_NS = 150;
   localparam int WRITE_HIGH_NS = 50;
   // Noise filter width in ns; our pulses stay far above it
   localparam int NOISE_NS = 8;
   // Cycle counts derived from times (least times round up)
   localparam int WRITE_LOW_CYC = (WRITE_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int WRITE_HIGH_CYC = (WRITE_HIGH_NS + CLK_NS - 1) / CLK_NS;
   localparam int LOAD_GAP_CYC = LOAD_GAP_NS / CLK_NS;
   localparam int PROG_MAX_CYC = PROG_MAX_MS * 1000000 / CLK_NS;
   localparam int POWER_LOCK_CYC = POWER_LOCK_MS * 1000000 / CLK_NS;
   // Command addresses (low fifteen bits) and data codes
   localparam logic [14:0] CMD_ADDR_A = 15'h5555;
   localparam logic [14:0] CMD_ADDR_B = 15'h2AAA;
   localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
   localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
   localparam logic [7:0] CMD_ARM = 8'hA0;
   localparam logic [7:0] CMD_ERASE_PRE = 8'h80;
   localparam logic [7:0] CMD_DISARM = 8'h20;
   // Polling status bit
   localparam int TOP_DATA_BIT = 7;
   // Request kinds
   typedef enum logic [1:0] {
      EPW_OP_PLAIN = 2'b00,
      EPW_OP_ARMED = 2'b01,
      EPW_OP_ARM = 2'b10,
      EPW_OP_DISARM = 2'b11
   } epw_op_t;
   // Controller states
   typedef enum logic [2:0] {
      EPW_IDLE = 3'b000,
      EPW_LOW = 3'b001,
      EPW_HIGH = 3'b010,
      EPW_WAIT = 3'b011,
      EPW_POLL = 3'b100,
      EPW_RECOV = 3'b101
   } epw_state_t;
endpackage : epw_pkg

// ===== rtl/epw_host.sv
// Host controller that drives page writes and protection commands to the EEPROM
`timescale 1ns/10ps
`default_nettype none
module epw_host #(
   parameter int ADDR_W = 19,               // Address width (512K organization)
   parameter int PAGE_BYTES = 128,          // Bytes per page
   parameter int PROG_CYC = epw_pkg::PROG_MAX_CYC,     // Programming time limit
   parameter int POWER_CYC = epw_pkg::POWER_LOCK_CYC,  // Power-up lockout
   parameter int GAP_CYC = epw_pkg::LOAD_GAP_CYC       // Longest gap allowed
) (
   input wire logic clk_in,
   input wire logic rst_in,
   // User request side
   input wire logic req_valid_in,
   input wire epw_pkg::epw_op_t req_op_in,
   input wire logic [ADDR_W-1:0] req_addr_in,
   input wire logic [7:0] req_count_in,
   output logic req_ready_out,
   input wire logic data_valid_in,
   input wire logic [7:0] data_in,
   output logic data_ready_out,
   output logic done_out,
   output logic timeout_out,
   // Device pins
   output logic [ADDR_W-1:0] mem_addr_out,
   output logic [7:0] mem_data_out,
   output logic mem_data_oe_out,
   input wire logic [7:0] mem_data_in,
   output logic mem_cs_n_out,
   output logic mem_we_n_out,
   output logic mem_oe_n_out
);
   import epw_pkg::*;

   localparam int CW = 32;
   localparam int IDX_W = $clog2(PAGE_BYTES);

   // Whole controller state
   typedef struct packed {
      epw_state_t st;
      epw_op_t op;
      logic [2:0] cmd_idx;      // Command byte position
      logic [2:0] cmd_len;      // Command bytes in this sequence
      logic [7:0] left;         // Data bytes still to load
      logic [CW-1:0] cnt;       // Phase timer
      logic [CW-1:0] pwr;       // Power-up lockout timer
      logic [ADDR_W-1:0] base;  // Block and page address
      logic [ADDR_W-1:0] addr;
      logic [7:0] data;
      logic [7:0] last;         // Last byte written, for polling
      logic is_cmd;             // Current pulse carries a command byte
      logic has_data;           // A data byte went out, so polling has a target
      logic done;
      logic tmo;
   } epw_s_t;

   epw_s_t s_reg;
   epw_s_t s_next;

   ////////////////////////////////////////////////////////////////////////////
   // Command byte data at a step of a sequence
   function automatic logic [7:0] cmd_data(input epw_op_t op, input logic [2:0] i);
      logic [7:0] d;
      d = CMD_UNLOCK1;
      case (i)
         3'h1: d = CMD_UNLOCK2;
         3'h2: d = (op == EPW_OP_DISARM) ? CMD_ERASE_PRE : CMD_ARM;
         3'h3: d = CMD_UNLOCK1;
         3'h4: d = CMD_UNLOCK2;
         3'h5: d = CMD_DISARM;
         default: d = CMD_UNLOCK1;
      endcase
      return d;
   endfunction : cmd_data

   // Command address; only the low bits are the code, the block rides above
   function automatic logic [ADDR_W-1:0] cmd_addr(input logic [ADDR_W-1:0] blk,
                                                  input logic [2:0] i);
      logic [ADDR_W-1:0] a;
      a = blk;
      a[14:0] = (i == 3'h1 || i == 3'h4) ? CMD_ADDR_B : CMD_ADDR_A;
      return a;
   endfunction : cmd_addr

   ////////////////////////////////////////////////////////////////////////////
   // Handshakes are combinational
   always_comb begin
      req_ready_out = (s_reg.st == EPW_IDLE) && (s_reg.pwr == '0);
      data_ready_out = (s_reg.st == EPW_WAIT) && !s_reg.is_cmd && (s_reg.left != 8'h00);
   end

   // Address and data come from flip-flops; write strobe low only in the low phase, select also low while polling
   always_comb begin
      mem_addr_out = s_reg.addr;
      mem_data_out = s_reg.data;
      mem_data_oe_out = (s_reg.st == EPW_LOW) || (s_reg.st == EPW_HIGH);
      mem_cs_n_out = !((s_reg.st == EPW_LOW) || (s_reg.st == EPW_POLL));
      mem_we_n_out = (s_reg.st != EPW_LOW);
      mem_oe_n_out = (s_reg.st != EPW_POLL);
      done_out = s_reg.done;
      timeout_out = s_reg.tmo;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      s_next = s_reg;
      s_next.done = 1'b0;
      if (s_reg.pwr != '0) begin
         s_next.pwr = s_reg.pwr - 1'b1;
      end
      case (s_reg.st)
         // Take a request and pick the sequence length
         EPW_IDLE: begin
            s_next.cnt = '0;
            if (req_valid_in && req_ready_out) begin
               s_next.op = req_op_in;
               s_next.tmo = 1'b0;
               s_next.base = req_addr_in;
               // First data byte of a plain load goes to the requested offset
               s_next.addr = req_addr_in;
               s_next.has_data = 1'b0;
               s_next.left = req_count_in;
               s_next.cmd_idx = 3'h0;
               case (req_op_in)
                  EPW_OP_PLAIN: s_next.cmd_len = 3'h0;
                  EPW_OP_DISARM: s_next.cmd_len = 3'h6;
                  default: s_next.cmd_len = 3'h3;
               endcase
               s_next.is_cmd = (req_op_in != EPW_OP_PLAIN);
               s_next.st = EPW_WAIT;
            end
         end
         // Pick next byte: command byte, data byte, or finish
         EPW_WAIT: begin
            s_next.cnt = s_reg.cnt + 1'b1;
            if (s_reg.is_cmd) begin
               s_next.addr = cmd_addr(s_reg.base, s_reg.cmd_idx);
               s_next.data = cmd_data(s_reg.op, s_reg.cmd_idx);
               s_next.cmd_idx = s_reg.cmd_idx + 3'h1;
               s_next.cnt = '0;
               s_next.st = EPW_LOW;
            end else if (s_reg.left == 8'h00) begin
               // Let the window lapse so the device starts programming
               s_next.cnt = '0;
               s_next.st = EPW_POLL;
            end else if (data_valid_in) begin
               s_next.data = data_in;
               s_next.last = data_in;
               s_next.has_data = 1'b1;
               s_next.left = s_reg.left - 8'h01;
               s_next.cnt = '0;
               s_next.st = EPW_LOW;
            end else if (s_reg.cnt >= CW'(GAP_CYC)) begin
               // Source stalled too long: page closes early
               s_next.tmo = 1'b1;
               s_next.left = 8'h00;
            end
         end
         // Strobes low, held for exactly the least pulse width
         EPW_LOW: begin
            s_next.cnt = s_reg.cnt + 1'b1;
            if (s_reg.cnt >= CW'(WRITE_LOW_CYC - 1)) begin
               s_next.cnt = '0;
               s_next.st = EPW_HIGH;
            end
         end
         // Strobes high, then advance address within the page
         EPW_HIGH: begin
            s_next.cnt = s_reg.cnt + 1'b1;
            if (s_reg.cnt >= CW'(WRITE_HIGH_CYC - 1)) begin
               s_next.cnt = '0;
               if (s_reg.is_cmd && s_reg.cmd_idx == s_reg.cmd_len) begin
                  // Last command byte: data starts at the requested address
                  s_next.is_cmd = 1'b0;
                  if (s_reg.left != 8'h00) begin
                     s_next.addr = s_reg.base;
                  end
               end else if (!s_reg.is_cmd && s_reg.left != 8'h00) begin
                  // Only low bits move; block and page stay fixed
                  s_next.addr = s_reg.base;
                  s_next.addr[IDX_W-1:0] = s_reg.addr[IDX_W-1:0] + 1'b1;
               end
               // After the last byte the address stays put, so polling reads it back
               s_next.st = EPW_WAIT;
               if (!s_reg.is_cmd) begin
                  s_next.base[IDX_W-1:0] = '0;
               end
            end
         end
         // Poll the last address until the top bit is true
         EPW_POLL: begin
            s_next.cnt = s_reg.cnt + 1'b1;
            if (s_reg.has_data && s_reg.cnt > CW'(GAP_CYC * 4) &&
                mem_data_in[TOP_DATA_BIT] == s_reg.last[TOP_DATA_BIT]) begin
               s_next.st = EPW_RECOV;
            end else if (s_reg.cnt >= CW'(PROG_CYC) + CW'(GAP_CYC * 4)) begin
               // Command-only loads have nothing to poll, so the full wait is normal;
               // a data byte that never reads back true was refused or lost
               s_next.tmo = s_reg.tmo || s_reg.has_data;
               s_next.st = EPW_RECOV;
            end
         end
         // One idle cycle, then report completion
         EPW_RECOV: begin
            s_next.done = 1'b1;
            s_next.st = EPW_IDLE;
         end
         default: s_next.st = EPW_IDLE;
      endcase
      if (rst_in) begin
         s_next = '0;
         s_next.st = EPW_IDLE;
         s_next.pwr = CW'(POWER_CYC);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Single register stage; reset is applied in the next-state logic
   always_ff @(posedge clk_in) begin
      s_reg <= s_next;
   end
endmodule : epw_host
`default_nettype wire

// ===== test/epw_host_chk.sv
// Pin-level assertions on the EEPROM host controller
`timescale 1ns/10ps
`default_nettype none
module epw_host_chk #(
   parameter int ADDR_W = 19,
   parameter int GAP_CYC = 50
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic req_valid_in,
   input wire logic req_ready_out,
   input wire logic [ADDR_W-1:0] mem_addr_out,
   input wire logic [7:0] mem_data_out,
   input wire logic mem_data_oe_out,
   input wire logic mem_cs_n_out,
   input wire logic mem_we_n_out,
   input wire logic mem_oe_n_out
);
   import epw_pkg::*;
   int low_cnt; // Cycles with strobe low
   int gap_cnt; // Cycles since strobe rose or a request was taken
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   sequence s_fall;
      $fell(mem_we_n_out);
   endsequence
   ////////////////////////////////////////////////////////////////////////
   // Counters kept apart so a long stall cannot hide a short pulse
   always_ff @(posedge clk_in) begin
      low_cnt <= (rst_in || mem_we_n_out) ? 0 : low_cnt + 1;
      gap_cnt <= (rst_in || !mem_we_n_out || (req_valid_in && req_ready_out)) ? 0 : gap_cnt + 1;
   end
   a_no_write_oe: assert property (!mem_oe_n_out |-> mem_we_n_out && !mem_data_oe_out)
      else $error("write strobe with output strobe");
   a_pulse_width: assert property ($rose(mem_we_n_out) |-> low_cnt == WRITE_LOW_CYC)
      else $error("write pulse width wrong");
   a_write_pins: assert property (!mem_we_n_out |-> !mem_cs_n_out && mem_data_oe_out)
      else $error("write without select or data");
   a_pulse_stable: assert property (!mem_we_n_out && $past(!mem_we_n_out)
      |-> $stable(mem_addr_out) && $stable(mem_data_out))
      else $error("address or data moved in pulse");
   a_load_gap: assert property (s_fall |-> gap_cnt <= GAP_CYC)
      else $error("byte load gap too long");
   a_arm_addr: assert property (s_fall ##0 mem_data_out == CMD_ARM
      |-> mem_addr_out[14:0] == CMD_ADDR_A)
      else $error("arm code at wrong address");
   a_disarm_addr: assert property (s_fall ##0 mem_data_out == CMD_DISARM
      |-> mem_addr_out[14:0] == CMD_ADDR_A)
      else $error("disarm code at wrong address");
   a_unlock_addr: assert property (s_fall ##0 mem_data_out == CMD_UNLOCK2
      |-> mem_addr_out[14:0] == CMD_ADDR_B)
      else $error("second unlock at wrong address");
endmodule : epw_host_chk
bind epw_host epw_host_chk #(.ADDR_W(ADDR_W), .GAP_CYC(GAP_CYC)) u_chk (.clk_in(clk_in),
   .rst_in(rst_in), .req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
   .mem_addr_out(mem_addr_out), .mem_data_out(mem_data_out), .mem_data_oe_out(mem_data_oe_out),
   .mem_cs_n_out(mem_cs_n_out), .mem_we_n_out(mem_we_n_out), .mem_oe_n_out(mem_oe_n_out));
`default_nettype wire

// ===== test/epw_mem_model.sv
// Behavioural EEPROM with page loading and block protection
`timescale 1ns/10ps
`default_nettype none
module epw_mem_model #(
   parameter int WIN_CYC = 100,
   parameter int PROG_CYC = 150
) (
   input wire logic clk_in,
   input wire logic [18:0] addr_in,
   input wire logic [7:0] data_in,
   input wire logic cs_n_in,
   input wire logic we_n_in,
   input wire logic oe_n_in,
   output logic [7:0] data_out
);
   import epw_pkg::*;
   logic [7:0] mem [int];
   logic [3:0] prot = 4'h0; // Ships disarmed, no reset clears it
   logic [18:0] pa [$];
   logic [7:0] pd [$];
   logic [18:0] la = '0;
   logic [7:0] ld = '0;
   logic [7:0] last = '0;
   logic wr_q = 1'b0;
   int win = 0;
   int busy = 0;
   wire wr = !cs_n_in && !we_n_in && oe_n_in;
   function automatic logic [7:0] peek(input int a);
      return mem.exists(a) ? mem[a] : 8'hFF;
   endfunction : peek
   function automatic bit hit(input int i, input logic [7:0] d, input logic [14:0] a);
      return pd[i] == d && pa[i][14:0] == a;
   endfunction : hit
   ////////////////////////////////////////////////////////////////////////
   // Window lapsed: decode commands, then program or drop the page
   task automatic commit();
      int s;
      logic [1:0] b;
      b = pa[pa.size()-1][18:17];
      s = 0;
      if (pa.size() > 2 && hit(0, CMD_UNLOCK1, CMD_ADDR_A) && hit(1, CMD_UNLOCK2, CMD_ADDR_B)) begin
         if (hit(2, CMD_ARM, CMD_ADDR_A)) begin
            s = 3;
            prot[b] = 1'b1;
         end else if (pa.size() > 5 && hit(2, CMD_ERASE_PRE, CMD_ADDR_A)
            && hit(3, CMD_UNLOCK1, CMD_ADDR_A) && hit(4, CMD_UNLOCK2, CMD_ADDR_B)
            && hit(5, CMD_DISARM, CMD_ADDR_A)) begin
            s = 6;
            prot[b] = 1'b0;
         end
      end
      if (s > 0 || !prot[b]) begin
         for (int i = s; i < pa.size(); i++) mem[pa[i]] = pd[i];
      end
      last = pd[pa.size()-1];
      pa.delete();
      pd.delete();
      busy = PROG_CYC;
   endtask : commit
   ////////////////////////////////////////////////////////////////////////
   // Pin sampling; released bus toggles so stale data never looks valid
   always @(posedge clk_in) begin
      if (wr) ld = data_in;
      if (wr && !wr_q) la = addr_in;
      if (!wr && wr_q && busy == 0) begin
         pa.push_back(la);
         pd.push_back(ld);
         win = 0;
      end else if (pa.size() > 0) begin
         win++;
         if (win >= WIN_CYC) commit();
      end else if (busy > 0) busy--;
      wr_q = wr;
      if (!cs_n_in && !oe_n_in && we_n_in)
         data_out <= (busy > 0) ? {~last[7], last[6:0]} : peek(addr_in);
      else
         data_out <= ~data_out;
   end
endmodule : epw_mem_model
`default_nettype wire

// ===== test/tb_epw_host.sv
// Testbench of the EEPROM host controller against the device model
`timescale 1ns/10ps
`default_nettype none
module tb_epw_host;
   import epw_pkg::*;
   logic clk_in;
   logic rst_in;
   logic req_valid_in;
   epw_op_t req_op_in;
   logic [18:0] req_addr_in;
   logic [7:0] req_count_in;
   logic data_valid_in;
   logic [7:0] data_in;
   logic req_ready_out, data_ready_out, done_out, timeout_out, mem_data_oe_out;
   logic mem_cs_n_out, mem_we_n_out, mem_oe_n_out;
   logic [18:0] mem_addr_out;
   logic [7:0] mem_data_out, mem_data_in;
   logic [7:0] src [0:3] = '{8'h3C, 8'hC3, 8'h96, 8'h69}; // No command codes here
   int src_i = 0, src_n = 0, num_errors = 0, check_count = 0;
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   epw_host #(.POWER_CYC(20), .PROG_CYC(200), .GAP_CYC(50)) DUT (.clk_in(clk_in), .rst_in(rst_in),
      .req_valid_in(req_valid_in), .req_op_in(req_op_in), .req_addr_in(req_addr_in),
      .req_count_in(req_count_in), .req_ready_out(req_ready_out), .data_valid_in(data_valid_in),
      .data_in(data_in), .data_ready_out(data_ready_out), .done_out(done_out),
      .timeout_out(timeout_out), .mem_addr_out(mem_addr_out), .mem_data_out(mem_data_out),
      .mem_data_oe_out(mem_data_oe_out), .mem_data_in(mem_data_in), .mem_cs_n_out(mem_cs_n_out),
      .mem_we_n_out(mem_we_n_out), .mem_oe_n_out(mem_oe_n_out));
   epw_mem_model u_mem (.clk_in(clk_in), .addr_in(mem_addr_out), .data_in(mem_data_out),
      .cs_n_in(mem_cs_n_out), .we_n_in(mem_we_n_out), .oe_n_in(mem_oe_n_out), .data_out(mem_data_in));
   ////////////////////////////////////////////////////////////////////////
   // Byte source: next byte after each taken one
   always @(posedge clk_in) begin
      if (data_valid_in && data_ready_out) begin
         src_i <= src_i + 1;
         data_in <= src[(src_i + 1) % 4];
         data_valid_in <= src_i + 1 < src_n;
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic run_op(input epw_op_t op, input logic [18:0] a, input int n, input logic tmo);
      int t;
      @(posedge clk_in);
      src_i <= 0;
      src_n <= n;
      data_in <= src[0];
      data_valid_in <= n > 0;
      req_valid_in <= 1'b1;
      req_op_in <= op;
      req_addr_in <= a;
      req_count_in <= 8'(n);
      // Outputs are looked at mid-cycle, where they have settled
      t = 0;
      @(negedge clk_in);
      while (req_ready_out !== 1'b1 && t < 100) begin
         @(negedge clk_in);
         t++;
      end
      // Request stands through the edge that takes it
      @(posedge clk_in);
      req_valid_in <= 1'b0;
      t = 0;
      @(negedge clk_in);
      while (done_out !== 1'b1 && t < 5000) begin
         @(negedge clk_in);
         t++;
      end
      check({7'h0, done_out}, 8'h01);
      check({7'h0, timeout_out}, {7'h0, tmo});
   endtask : run_op
   task automatic t_lockout();
      @(negedge clk_in);
      check({7'h0, req_ready_out}, 8'h00);
      repeat (25) @(negedge clk_in);
      check({7'h0, req_ready_out}, 8'h01);
   endtask : t_lockout
   task automatic t_pages();
      run_op(EPW_OP_PLAIN, 19'h00010, 3, 1'b0);
      check(u_mem.peek(32'h10), 8'h3C);
      check(u_mem.peek(32'h12), 8'h96);
   endtask : t_pages
   task automatic t_protect();
      run_op(EPW_OP_ARM, 19'h20000, 0, 1'b0);
      check({4'h0, u_mem.prot}, 8'h02);
      // Refused write never reads back true, so the host flags it
      run_op(EPW_OP_PLAIN, 19'h20080, 1, 1'b1);
      check(u_mem.peek(32'h20080), 8'hFF);
      run_op(EPW_OP_ARMED, 19'h20080, 2, 1'b0);
      check(u_mem.peek(32'h20081), 8'hC3);
      run_op(EPW_OP_DISARM, 19'h20000, 0, 1'b0);
      check({4'h0, u_mem.prot}, 8'h00);
      run_op(EPW_OP_PLAIN, 19'h200C0, 1, 1'b0);
      check(u_mem.peek(32'h200C0), 8'h3C);
   endtask : t_protect
   task automatic final_report();
      $display("Checks %0d, errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : final_report
   initial begin
      rst_in = 1'b1;
      req_valid_in = 1'b0;
      req_op_in = EPW_OP_PLAIN;
      req_addr_in = '0;
      req_count_in = '0;
      data_valid_in = 1'b0;
      data_in = '0;
      repeat (8) @(posedge clk_in);
      rst_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      t_lockout();
      t_pages();
      t_protect();
      final_report();
   end
   initial begin
      repeat (20000) @(posedge clk_in);
      num_errors++;
      final_report();
   end
endmodule : tb_epw_host
`default_nettype wire
